// [host_model.sv]
// Host model driving the block's register port.
// Assumes the bench calls its tasks; signals move at the falling edge.
`timescale 1ns/10ps
module host_model (
    // Clock
    input wire i_clk_sys,
    // Read return
    input wire [7:0] i_rdata,
    input wire i_rvalid,
    input wire [7:0] i_next,
    // Register port
    output reg [7:0] o_addr,
    output reg o_wr,
    output reg [7:0] o_wdata,
    output reg o_rd
);
    initial begin
        o_addr = 8'h00;
        o_wr = 1'b0;
        o_wdata = 8'h00;
        o_rd = 1'b0;
    end
    task wr(input [7:0] a, input [7:0] d);
        begin
            @(negedge i_clk_sys);
            o_addr = a;
            o_wdata = d;
            o_wr = 1'b1;
            @(negedge i_clk_sys);
            o_wr = 1'b0;
            // Stale data would hide a write taken late
            o_wdata = ~d;
        end
    endtask
    task rd(input [7:0] a, output [7:0] d, output [7:0] n);
        begin
            @(negedge i_clk_sys);
            o_addr = a;
            o_rd = 1'b1;
            @(negedge i_clk_sys);
            o_rd = 1'b0;
            d = (i_rvalid === 1'b1) ? i_rdata : 8'hxx;
            n = i_next;
        end
    endtask
    task poll_stby(output ok);
        reg [7:0] d;
        reg [7:0] n;
        integer k;
        begin
            ok = 1'b0;
            for (k = 0; k < 40 && !ok; k = k + 1) begin
                rd(8'h0b, d, n);
                ok = (d[1:0] === 2'h0);
            end
        end
    endtask
endmodule

// [mag_hybrid_consts.vh]
// Constants for the magnetometer hybrid control block.
// Included by the control file; definitions only.
`ifndef MAG_HYBRID_CONSTS_VH
`define MAG_HYBRID_CONSTS_VH

`define MHC_ADDR_SYSMODE 8'h0b
`define MHC_ADDR_CTRL_TWO 8'h5c
`define MHC_ADDR_OUT_Z_MSB 8'h05
`define MHC_ADDR_OUT_Z_LSB 8'h06
`define MHC_ADDR_MAG_FIRST 8'h33
`define MHC_ADDR_CMP_LAST 8'h3e
`define MHC_CTRL_TWO_RESET 8'h00
`define MHC_BIT_AUTOINC 5
`define MHC_BIT_MAXMIN_DIS 4
`define MHC_BIT_DIS_THS 3
`define MHC_BIT_MM_RST 2
`define MHC_BIT_RSTCNT_HI 1
`define MHC_BIT_RSTCNT_LO 0
`define MHC_HMS_ACCEL 2'h0
`define MHC_HMS_MAG 2'h1
`define MHC_HMS_HYBRID 2'h3
`define MHC_DEG_EVERY 2'h0
`define MHC_DEG_16 2'h1
`define MHC_DEG_512 2'h2
`define MHC_DEG_LAST_16 4'hf
`define MHC_DEG_LAST_512 9'h1ff
`define MHC_MIN_RESET 16'h7fff
`define MHC_MAX_RESET 16'h8000
`define MHC_SYSMODE_STBY 2'h0
`define MHC_SYSMODE_WAKE 2'h1
`define MHC_SYSMODE_SLEEP 2'h2
`define MHC_CLK_NS 100
`define MHC_BASE_ODR_NS 1250000
`define MHC_STBY_MAX_NS 300000000

`endif

// [magnetometer_hybrid_control.v]
// Magnetometer hybrid control: sensor select, ODR timing, output placement,
// burst auto-increment, degauss scheduling and min/max tracking.
// Assumes synchronous inputs on a 10 MHz clock and a byte register port.
// Operation
// - 0b11 selects hybrid, both sensors run
// - Hybrid halves each sensor's sample rate
// - Mag update from oversample and system ODR
// - Mag at 0x33-0x38, synced accel 0x39-0x3E
// - Standby entry may lag up to 300 ms
// - Autoinc, no fast-read: 0x06 jumps 0x33
// - Autoinc, fast-read: 0x05 jumps 0x33
// - Min/max disable bit gates tracking
// - Control two at 0x5C, fields, reset zero
// - 0b00 accel only, 0b01 mag only
// - Min/max reset loads 0x7FFF/0x8000, self-clears
// - Threshold event may stop min/max tracking
// - Degauss every 1, 16, 512 cycles or never
`timescale 1ns/10ps
`include "mag_hybrid_consts.vh"
module magnetometer_hybrid_control #(
    parameter BASE_ODR_CYCLES = `MHC_BASE_ODR_NS / `MHC_CLK_NS,
    parameter STBY_MAX_CYCLES = `MHC_STBY_MAX_NS / `MHC_CLK_NS
) (
    // Clock and reset
    input wire i_clk_sys,
    input wire i_srst,
    // System control bits
    input wire i_active,
    input wire i_sleep,
    input wire i_fast_read,
    input wire [2:0] i_data_rate_sel,
    input wire [1:0] i_aslp_rate,
    input wire [1:0] i_sensor_select,
    input wire [2:0] i_mag_oversample,
    input wire i_manual_degauss,
    input wire i_mag_ths_event,
    // Sensor results
    input wire [47:0] i_mag_xyz,
    input wire [47:0] i_accel_xyz,
    // Register port
    input wire [7:0] i_reg_addr,
    input wire i_reg_wr,
    input wire [7:0] i_reg_wdata,
    input wire i_reg_rd,
    output reg [7:0] o_reg_rdata,
    output reg o_reg_rvalid,
    output reg [7:0] o_next_addr,
    // Sensor control
    output reg o_accel_en,
    output reg o_mag_en,
    output reg o_accel_sample,
    output reg o_mag_start,
    output reg o_mag_ready,
    output reg o_degauss,
    output reg [1:0] o_sys_mode,
    output reg o_minmax_track,
    // Min/max readback
    input wire [2:0] i_minmax_sel,
    output wire [15:0] o_minmax_data
);
    localparam ST_STBY = 2'h0;
    localparam ST_ACT = 2'h1;
    localparam ST_DRAIN = 2'h2;
    localparam MM_IDLE = 2'h0;
    localparam MM_RST = 2'h1;
    localparam MM_RD = 2'h2;
    localparam MM_CMP = 2'h3;

    reg [1:0] state;
    reg [23:0] odr_cnt;
    reg [21:0] stby_cnt;
    reg phase;
    reg [7:0] osr_cnt;
    reg osr_busy;
    reg [8:0] deg_cnt;
    reg [7:0] ctrl_two;
    reg [47:0] mag_out;
    reg [47:0] cmp_out;
    reg ths_stopped;
    reg [1:0] mm_state;
    reg [2:0] mm_idx;
    reg [2:0] mm_wr_addr;
    reg mm_wr;
    reg [15:0] mm_wdata;
    reg [1:0] next_state;
    wire [15:0] mm_rdata;
    wire odr_tick;
    wire hybrid;
    wire mag_tick;
    wire accel_tick;
    wire [23:0] odr_period;
    wire mm_rst_done;
    wire track_en;
    wire [15:0] axis_val;

    // 1.56 Hz needs a shift of 9 over the 800 Hz base
    function [3:0] rate_shift;
        input [2:0] code;
        begin
            case (code)
                3'h5: rate_shift = 4'h6;
                3'h6: rate_shift = 4'h7;
                3'h7: rate_shift = 4'h9;
                default: rate_shift = {1'b0, code};
            endcase
        end
    endfunction

    function [15:0] axis_word;
        input [47:0] xyz;
        input [1:0] axis;
        begin
            case (axis)
                2'h0: axis_word = xyz[47:32];
                2'h1: axis_word = xyz[31:16];
                default: axis_word = xyz[15:0];
            endcase
        end
    endfunction

    function [7:0] out_byte;
        input [95:0] bank;
        input [7:0] addr;
        reg [7:0] off;
        reg [3:0] idx;
        begin
            off = addr - `MHC_ADDR_MAG_FIRST;
            idx = off[3:0];
            out_byte = bank[95 - 8 * idx -: 8];
        end
    endfunction

    assign hybrid = (i_sensor_select == `MHC_HMS_HYBRID);
    assign odr_period = BASE_ODR_CYCLES[23:0] << (i_sleep ? rate_shift({1'b1, i_aslp_rate})
                                                         : rate_shift(i_data_rate_sel));
    assign odr_tick = (state != ST_STBY) && (odr_cnt >= odr_period - 24'h1);
    assign accel_tick = odr_tick && (i_sensor_select == `MHC_HMS_ACCEL || (hybrid && !phase));
    assign mag_tick = odr_tick && (i_sensor_select == `MHC_HMS_MAG || (hybrid && phase));
    assign mm_rst_done = (mm_state == MM_RST) && (mm_idx == 3'h5);
    // Disable bit and threshold stop gate
    assign track_en = !ctrl_two[`MHC_BIT_MAXMIN_DIS] && !ths_stopped;
    assign axis_val = axis_word(mag_out, (mm_idx >= 3'h3) ? mm_idx[1:0] - 2'h3 : mm_idx[1:0]);

    minmax_store #(
        .WIDTH(16),
        .DEPTH(8),
        .AW(3)
    ) u_store (
        .i_clk_sys(i_clk_sys),
        .i_wr_en(mm_wr),
        .i_wr_addr(mm_wr_addr),
        .i_wr_data(mm_wdata),
        .i_rd_addr_a(mm_idx),
        .o_rd_data_a(mm_rdata),
        .i_rd_addr_b(i_minmax_sel),
        .o_rd_data_b(o_minmax_data)
    );

    // Drain the current cycle, capped at 300 ms
    always @* begin
        next_state = state;
        case (state)
            ST_STBY: begin
                if (i_active) begin
                    next_state = ST_ACT;
                end
            end
            ST_ACT: begin
                if (!i_active) begin
                    next_state = (i_sensor_select == `MHC_HMS_ACCEL) ? ST_STBY : ST_DRAIN;
                end
            end
            ST_DRAIN: begin
                if (odr_tick || stby_cnt >= STBY_MAX_CYCLES[21:0] - 22'h1) begin
                    next_state = ST_STBY;
                end
            end
            default: next_state = ST_STBY;
        endcase
    end

    always @(posedge i_clk_sys) begin
        if (i_srst) begin
            state <= ST_STBY;
            odr_cnt <= 24'h0;
            stby_cnt <= 22'h0;
            phase <= 1'b0;
            o_sys_mode <= `MHC_SYSMODE_STBY;
            o_accel_en <= 1'b0;
            o_mag_en <= 1'b0;
            o_accel_sample <= 1'b0;
            o_mag_start <= 1'b0;
        end else begin
            state <= next_state;
            odr_cnt <= (odr_tick || state == ST_STBY) ? 24'h0 : odr_cnt + 24'h1;
            stby_cnt <= (state == ST_DRAIN) ? stby_cnt + 22'h1 : 22'h0;
            phase <= (state == ST_STBY) ? 1'b0 : phase ^ odr_tick;
            if (next_state == ST_STBY) begin
                o_sys_mode <= `MHC_SYSMODE_STBY;
            end else begin
                o_sys_mode <= i_sleep ? `MHC_SYSMODE_SLEEP : `MHC_SYSMODE_WAKE;
            end
            o_accel_en <= (next_state != ST_STBY) && (i_sensor_select != `MHC_HMS_MAG);
            o_mag_en <= (next_state != ST_STBY) && (i_sensor_select != `MHC_HMS_ACCEL);
            o_accel_sample <= accel_tick;
            o_mag_start <= mag_tick;
        end
    end

    always @(posedge i_clk_sys) begin
        if (i_srst) begin
            osr_cnt <= 8'h0;
            osr_busy <= 1'b0;
            o_mag_ready <= 1'b0;
            mag_out <= 48'h0;
            cmp_out <= 48'h0;
        end else begin
            o_mag_ready <= 1'b0;
            if (mag_tick) begin
                osr_busy <= 1'b1;
                osr_cnt <= 8'h0;
            end else if (osr_busy) begin
                osr_cnt <= osr_cnt + 8'h1;
                if (osr_cnt == (8'h1 << i_mag_oversample) - 8'h1) begin
                    osr_busy <= 1'b0;
                    o_mag_ready <= 1'b1;
                    mag_out <= i_mag_xyz;
                    // Accel captured with the mag result
                    if (hybrid) begin
                        cmp_out <= i_accel_xyz;
                    end
                end
            end
        end
    end

    always @(posedge i_clk_sys) begin
        if (i_srst) begin
            deg_cnt <= 9'h0;
            o_degauss <= 1'b0;
        end else begin
            if (state == ST_STBY) begin
                deg_cnt <= 9'h0;
            end else if (mag_tick) begin
                deg_cnt <= deg_cnt + 9'h1;
            end
            case (ctrl_two[`MHC_BIT_RSTCNT_HI:`MHC_BIT_RSTCNT_LO])
                `MHC_DEG_EVERY: o_degauss <= mag_tick;
                `MHC_DEG_16: o_degauss <= mag_tick && deg_cnt[3:0] == `MHC_DEG_LAST_16;
                `MHC_DEG_512: o_degauss <= mag_tick && deg_cnt == `MHC_DEG_LAST_512;
                default: o_degauss <= 1'b0;
            endcase
            if ((state == ST_STBY && next_state == ST_ACT && i_sensor_select != `MHC_HMS_ACCEL)
                || i_manual_degauss) begin
                o_degauss <= 1'b1;
            end
        end
    end

    always @(posedge i_clk_sys) begin
        if (i_srst) begin
            ctrl_two <= `MHC_CTRL_TWO_RESET;
        end else if (i_reg_wr && i_reg_addr == `MHC_ADDR_CTRL_TWO) begin
            ctrl_two <= i_reg_wdata;
        end else if (mm_rst_done) begin
            ctrl_two[`MHC_BIT_MM_RST] <= 1'b0;
        end
    end

    // Threshold stop, set wins over clear
    always @(posedge i_clk_sys) begin
        if (i_srst) begin
            ths_stopped <= 1'b0;
        end else if (i_mag_ths_event && ctrl_two[`MHC_BIT_DIS_THS]) begin
            ths_stopped <= 1'b1;
        end else if (mm_rst_done || !ctrl_two[`MHC_BIT_DIS_THS]) begin
            ths_stopped <= 1'b0;
        end
    end

    // Entries 0-2 are minima, 3-5 maxima
    always @(posedge i_clk_sys) begin
        if (i_srst) begin
            mm_state <= MM_IDLE;
            mm_idx <= 3'h0;
            mm_wr_addr <= 3'h0;
            mm_wr <= 1'b0;
            mm_wdata <= 16'h0;
            o_minmax_track <= 1'b0;
        end else begin
            mm_wr <= 1'b0;
            o_minmax_track <= track_en;
            case (mm_state)
                MM_IDLE: begin
                    mm_idx <= 3'h0;
                    if (ctrl_two[`MHC_BIT_MM_RST]) begin
                        mm_state <= MM_RST;
                        mm_wr_addr <= 3'h0;
                        mm_wr <= 1'b1;
                        mm_wdata <= `MHC_MIN_RESET;
                    end else if (o_mag_ready && track_en) begin
                        mm_state <= MM_RD;
                    end
                end
                MM_RST: begin
                    if (mm_idx == 3'h5) begin
                        mm_state <= MM_IDLE;
                    end else begin
                        mm_idx <= mm_idx + 3'h1;
                        mm_wr_addr <= mm_idx + 3'h1;
                        mm_wr <= 1'b1;
                        mm_wdata <= (mm_idx >= 3'h2) ? `MHC_MAX_RESET : `MHC_MIN_RESET;
                    end
                end
                MM_RD: begin
                    mm_state <= MM_CMP;
                end
                MM_CMP: begin
                    // Own write address lets the next read overlap the write-back
                    mm_wr_addr <= mm_idx;
                    if ((mm_idx < 3'h3 && $signed(axis_val) < $signed(mm_rdata)) ||
                        (mm_idx >= 3'h3 && $signed(axis_val) > $signed(mm_rdata))) begin
                        mm_wr <= 1'b1;
                        mm_wdata <= axis_val;
                    end
                    mm_state <= MM_IDLE;
                    if (mm_idx != 3'h5) begin
                        mm_idx <= mm_idx + 3'h1;
                        mm_state <= MM_RD;
                    end
                end
                default: mm_state <= MM_IDLE;
            endcase
        end
    end

    // Register reads and burst address
    always @(posedge i_clk_sys) begin
        if (i_srst) begin
            o_reg_rdata <= 8'h0;
            o_reg_rvalid <= 1'b0;
            o_next_addr <= 8'h0;
        end else begin
            o_reg_rvalid <= i_reg_rd;
            if (i_reg_rd) begin
                if (i_reg_addr == `MHC_ADDR_SYSMODE) begin
                    o_reg_rdata <= {6'h0, o_sys_mode};
                end else if (i_reg_addr == `MHC_ADDR_CTRL_TWO) begin
                    o_reg_rdata <= ctrl_two;
                end else if (i_reg_addr >= `MHC_ADDR_MAG_FIRST &&
                             i_reg_addr <= `MHC_ADDR_CMP_LAST) begin
                    o_reg_rdata <= out_byte({mag_out, cmp_out}, i_reg_addr);
                end else begin
                    o_reg_rdata <= 8'h0;
                end
                if (ctrl_two[`MHC_BIT_AUTOINC] && !i_fast_read &&
                    i_reg_addr == `MHC_ADDR_OUT_Z_LSB) begin
                    o_next_addr <= `MHC_ADDR_MAG_FIRST;
                // Fast-read jumps after Z high byte
                end else if (ctrl_two[`MHC_BIT_AUTOINC] && i_fast_read &&
                             i_reg_addr == `MHC_ADDR_OUT_Z_MSB) begin
                    o_next_addr <= `MHC_ADDR_MAG_FIRST;
                end else begin
                    o_next_addr <= i_reg_addr + 8'h1;
                end
            end
        end
    end
endmodule

// [magnetometer_hybrid_control_bench.sv]
// Self-checking bench for the magnetometer hybrid control block.
// Assumes the host model on the register port and the bound checker.
`timescale 1ns/10ps
module magnetometer_hybrid_control_bench;
    reg clk, srst, active, fast_read, ths_event, manual_deg, ok, sleep;
    reg [2:0] odr, osr, mm_sel;
    reg [1:0] sel;
    reg [47:0] mag, acc;
    reg [63:0] r;
    reg [7:0] d, n, a;
    wire [7:0] addr, wdata, rdata, next_addr;
    wire wr, rd, rvalid, accel_en, mag_en, mag_ready, degauss, track;
    wire [1:0] sys_mode;
    wire [15:0] mm_data;
    integer n_mismatch, checked, seed, i, s, j;
    // Short counts keep the run brief
    magnetometer_hybrid_control #(.BASE_ODR_CYCLES(20), .STBY_MAX_CYCLES(50)) dut_u (
        .i_clk_sys(clk), .i_srst(srst), .i_active(active), .i_sleep(sleep),
        .i_fast_read(fast_read), .i_data_rate_sel(odr), .i_aslp_rate(2'h0),
        .i_sensor_select(sel), .i_mag_oversample(osr), .i_manual_degauss(manual_deg),
        .i_mag_ths_event(ths_event), .i_mag_xyz(mag), .i_accel_xyz(acc),
        .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_wdata(wdata), .i_reg_rd(rd),
        .o_reg_rdata(rdata), .o_reg_rvalid(rvalid), .o_next_addr(next_addr),
        .o_accel_en(accel_en), .o_mag_en(mag_en), .o_accel_sample(), .o_mag_start(),
        .o_mag_ready(mag_ready), .o_degauss(degauss), .o_sys_mode(sys_mode),
        .o_minmax_track(track), .i_minmax_sel(mm_sel), .o_minmax_data(mm_data));
    host_model host_u (.i_clk_sys(clk), .i_rdata(rdata), .i_rvalid(rvalid),
        .i_next(next_addr), .o_addr(addr), .o_wr(wr), .o_wdata(wdata), .o_rd(rd));
    function [7:0] exp_byte(input [7:0] ad, input [47:0] m, input [47:0] c);
        reg [95:0] bank;
        begin
            bank = {m, c} >> (88 - 8 * (ad - 8'h33));
            exp_byte = bank[7:0];
        end
    endfunction
    task chk_val(input string name, input [15:0] e, input [15:0] g);
        begin
            checked = checked + 1;
            if (g !== e) begin
                n_mismatch = n_mismatch + 1;
                $display("Error %s expected %h seen %h", name, e, g);
            end
        end
    endtask
    task chk_bit(input string name, input e, input g);
        chk_val(name, {15'h0, e}, {15'h0, g});
    endtask
    task conclude;
        begin
            $display("Compared %0d, mismatched %0d", checked, n_mismatch);
            if (n_mismatch == 0 && checked > 0)
                $display("DONE - PASS");
            else
                $display("DONE - FAIL");
            $finish;
        end
    endtask
    task wait_ready;
        integer k;
        begin
            for (k = 0; k < 600 && mag_ready !== 1'b1; k = k + 1)
                @(negedge clk);
            chk_bit("mag_ready", 1'b1, mag_ready);
        end
    endtask
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch = n_mismatch + 1;
        conclude;
    end
    initial begin
        seed = 32'he06b3319;
        n_mismatch = 0;
        checked = 0;
        {srst, active, fast_read, ths_event, manual_deg} = 5'h10;
        sleep = 1'b0;
        {odr, osr, mm_sel, sel} = 11'h000;
        mag = 48'h0;
        acc = 48'h0;
        repeat (3) @(negedge clk);
        srst = 1'b0;
        host_u.rd(8'h5c, d, n);
        chk_val("ctrl_two", 16'h00, d);
        host_u.rd(8'h10, d, n);
        chk_val("unmapped", 16'h00, d);
        host_u.wr(8'h5c, 8'hc3);
        host_u.rd(8'h5c, d, n);
        chk_val("ctrl_two", 16'hc3, d);
        // Autoinc on, automatic degauss off
        host_u.wr(8'h5c, 8'h23);
        host_u.rd(8'h06, d, n);
        chk_val("next_addr", 16'h33, n);
        fast_read = 1'b1;
        host_u.rd(8'h05, d, n);
        chk_val("next_addr", 16'h33, n);
        host_u.rd(8'h06, d, n);
        chk_val("next_addr", 16'h07, n);
        fast_read = 1'b0;
        for (i = 0; i < 3; i = i + 1) begin
            s = (i == 2) ? 3 : i;
            sel = s[1:0];
            r = {$random(seed), $random(seed)};
            odr = {2'h0, r[0]};
            osr = {1'b0, r[2:1]};
            mag = r[63:16];
            r = {$random(seed), $random(seed)};
            acc = r[47:0];
            active = 1'b1;
            repeat (3) @(negedge clk);
            chk_bit("accel_en", s != 1, accel_en);
            chk_bit("mag_en", s != 0, mag_en);
            if (s != 0) begin
                wait_ready;
                for (a = 8'h33; a <= ((s == 3) ? 8'h3e : 8'h38); a = a + 8'h01) begin
                    host_u.rd(a, d, n);
                    chk_val("result_byte", exp_byte(a, mag, acc), d);
                end
                manual_deg = 1'b1;
                @(negedge clk);
                manual_deg = 1'b0;
                chk_bit("degauss", 1'b1, degauss);
                // Degauss on every mag tick
                host_u.wr(8'h5c, 8'h20);
                for (j = 0; j < 100 && degauss !== 1'b1; j = j + 1)
                    @(negedge clk);
                chk_bit("degauss", 1'b1, degauss);
            end
            active = 1'b0;
            host_u.poll_stby(ok);
            chk_bit("standby", 1'b1, ok && sys_mode === 2'h0);
        end
        host_u.wr(8'h5c, 8'h04);
        d = 8'h04;
        for (i = 0; i < 10 && d[2] !== 1'b0; i = i + 1)
            host_u.rd(8'h5c, d, n);
        chk_val("ctrl_two", 16'h00, d);
        for (i = 0; i < 6; i = i + 1) begin
            mm_sel = i[2:0];
            @(negedge clk);
            chk_val("minmax", (i < 3) ? 16'h7fff : 16'h8000, mm_data);
        end
        chk_bit("track", 1'b1, track);
        host_u.wr(8'h5c, 8'h10);
        @(negedge clk);
        chk_bit("track", 1'b0, track);
        host_u.wr(8'h5c, 8'h08);
        @(negedge clk);
        chk_bit("track", 1'b1, track);
        ths_event = 1'b1;
        @(negedge clk);
        ths_event = 1'b0;
        @(negedge clk);
        chk_bit("track", 1'b0, track);
        host_u.wr(8'h5c, 8'h00);
        repeat (2) @(negedge clk);
        chk_bit("track", 1'b1, track);
        // One sample after a min/max reset sets both bounds, at the sleep rate
        sel = 2'h1;
        sleep = 1'b1;
        active = 1'b1;
        wait_ready;
        host_u.rd(8'h0b, d, n);
        chk_val("sys_mode", 16'h02, d);
        repeat (20) @(negedge clk);
        for (i = 0; i < 6; i = i + 1) begin
            mm_sel = i[2:0];
            @(negedge clk);
            chk_val("minmax", mag[47 - 16 * (i % 3) -: 16], mm_data);
        end
        active = 1'b0;
        host_u.poll_stby(ok);
        chk_bit("standby", 1'b1, ok && sys_mode === 2'h0);
        sleep = 1'b0;
        conclude;
    end
endmodule

// [magnetometer_hybrid_control_properties.sv]
// Checker for the magnetometer hybrid control block, bound to its top.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps
module magnetometer_hybrid_control_properties #(
    parameter STBY_MAX_CYCLES = 50
) (
    input wire i_clk_sys,
    input wire i_srst,
    input wire i_active,
    input wire i_fast_read,
    input wire [1:0] i_sensor_select,
    input wire [7:0] i_reg_addr,
    input wire i_reg_wr,
    input wire [7:0] i_reg_wdata,
    input wire i_reg_rd,
    input wire [7:0] o_reg_rdata,
    input wire o_reg_rvalid,
    input wire [7:0] o_next_addr,
    input wire o_accel_sample,
    input wire o_mag_start,
    input wire [1:0] o_sys_mode,
    input wire o_minmax_track
);
    // Shadow of control two; bit 2 self-clears, so it is left out
    reg [7:0] ctl;
    integer wait_cnt;
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_srst);
    always @(posedge i_clk_sys) begin
        if (i_srst)
            ctl <= 8'h00;
        else if (i_reg_wr && i_reg_addr == 8'h5c)
            ctl <= i_reg_wdata & 8'hfb;
    end
    always @(posedge i_clk_sys) begin
        if (i_srst || i_active || o_sys_mode == 2'h0)
            wait_cnt <= 0;
        else
            wait_cnt <= wait_cnt + 1;
    end
    a_rvalid_follows: assert property (i_reg_rd |=> o_reg_rvalid)
        else $error("read not answered");
    a_rvalid_cause: assert property (o_reg_rvalid |-> $past(i_reg_rd))
        else $error("read answer without request");
    a_ctrl_readback: assert property (
        i_reg_rd && !i_reg_wr && i_reg_addr == 8'h5c |=> (o_reg_rdata & 8'hfb) == ctl)
        else $error("control two readback wrong");
    a_skip_plain: assert property (
        i_reg_rd && i_reg_addr == 8'h06 && ctl[5] && !i_fast_read |=> o_next_addr == 8'h33)
        else $error("burst skip after 0x06 missing");
    a_skip_fast: assert property (
        i_reg_rd && i_reg_addr == 8'h05 && ctl[5] && i_fast_read |=> o_next_addr == 8'h33)
        else $error("burst skip after 0x05 missing");
    a_mag_cause: assert property (o_mag_start |-> $past(i_sensor_select[0]))
        else $error("mag started while not selected");
    a_accel_cause: assert property (o_accel_sample |-> $past(i_sensor_select) != 2'h1)
        else $error("accel sampled in mag-only mode");
    a_hybrid_halves: assert property (
        o_mag_start && i_sensor_select == 2'h3 |-> !o_accel_sample ##1 !o_mag_start)
        else $error("hybrid slots not alternating");
    a_minmax_off: assert property (ctl[4] && $past(ctl[4]) |-> !o_minmax_track)
        else $error("tracking while disabled");
    a_stby_bound: assert property (wait_cnt <= STBY_MAX_CYCLES + 2)
        else $error("standby entry too late");
    cover property (o_mag_start && i_sensor_select == 2'h3);
    cover property (i_reg_rd && i_reg_addr == 8'h06 && ctl[5]);
    cover property ($fell(i_active) && o_sys_mode != 2'h0);
endmodule
bind magnetometer_hybrid_control magnetometer_hybrid_control_properties #(
    .STBY_MAX_CYCLES(STBY_MAX_CYCLES)
) chk_u (
    .i_clk_sys, .i_srst, .i_active, .i_fast_read, .i_sensor_select,
    .i_reg_addr, .i_reg_wr, .i_reg_wdata, .i_reg_rd, .o_reg_rdata, .o_reg_rvalid,
    .o_next_addr, .o_accel_sample, .o_mag_start, .o_sys_mode, .o_minmax_track
);

// [minmax_store.v]
// Min/max word storage: one write port, two registered read ports.
// Assumes the single system clock; no reset, contents set by the control logic.
`timescale 1ns/10ps
module minmax_store #(
    parameter WIDTH = 16,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    // Clock
    input wire i_clk_sys,
    // Write port
    input wire i_wr_en,
    input wire [AW-1:0] i_wr_addr,
    input wire [WIDTH-1:0] i_wr_data,
    // Read ports
    input wire [AW-1:0] i_rd_addr_a,
    output reg [WIDTH-1:0] o_rd_data_a,
    input wire [AW-1:0] i_rd_addr_b,
    output reg [WIDTH-1:0] o_rd_data_b
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];

    always @(posedge i_clk_sys) begin
        if (i_wr_en) begin
            mem[i_wr_addr] <= i_wr_data;
        end
        o_rd_data_a <= mem[i_rd_addr_a];
        o_rd_data_b <= mem[i_rd_addr_b];
    end
endmodule
